/* src/nvm_self_access_pkg.sv */
// package: register map, control fields, operation codes and carriers for the nvm self-access block
package nvm_self_access_pkg;

    // --------
    // register offsets (byte addresses on apb)
    // --------
    localparam logic [7:0] OFS_DATA_LOW = 8'h00;
    localparam logic [7:0] OFS_DATA_HIGH = 8'h04;
    localparam logic [7:0] OFS_ADDR_LOW = 8'h08;
    localparam logic [7:0] OFS_ADDR_HIGH = 8'h0C;
    localparam logic [7:0] OFS_CONTROL = 8'h10;
    localparam logic [7:0] OFS_UNLOCK = 8'h14;

    // --------
    // control register field positions
    // --------
    localparam int BIT_PROGRAM_SPACE = 7;
    localparam int BIT_CONFIG_SPACE = 6;
    localparam int BIT_LATCH_ONLY = 5;
    localparam int BIT_ERASE = 4;
    localparam int BIT_WRITE_ENABLE = 2;
    localparam int BIT_WRITE_START = 1;
    localparam int BIT_READ_START = 0;

    // --------
    // reset values and erased-word value
    // --------
    localparam logic [7:0] RST_ADDR_LOW = 8'h00;
    localparam logic [6:0] RST_ADDR_HIGH = 7'h00;
    localparam logic [13:0] RST_USER_ID = 14'h3FFF;
    localparam logic [13:0] ERASED_WORD = 14'h3FFF;

    // --------
    // unlock keys and configuration-space addresses (full 15-bit address pair, msb=0)
    // --------
    localparam logic [7:0] UNLOCK_KEY_FIRST = 8'h55;
    localparam logic [7:0] UNLOCK_KEY_SECOND = 8'hAA;
    localparam logic [14:0] CFG_USER_ID_LAST = 15'h0003;
    localparam logic [14:0] CFG_DEVICE_ID = 15'h0006;
    localparam logic [14:0] CFG_WORD_1 = 15'h0007;
    localparam logic [14:0] CFG_WORD_2 = 15'h0008;

    // --------
    // types
    // --------
    typedef enum logic [2:0] {
        OP_READ_PROGRAM,
        OP_READ_EEPROM,
        OP_ERASE_ROW,
        OP_LOAD_LATCH,
        OP_PROGRAM_ROW,
        OP_WRITE_EEPROM
    } mem_op_type;

    typedef struct packed {
        logic valid;
        mem_op_type op;
        logic [14:0] addr;
        logic [13:0] wdata;
    } mem_req_type;

    typedef struct packed {
        logic done;
        logic [13:0] rdata;
    } mem_rsp_type;

endpackage : nvm_self_access_pkg

/* src/program_memory_self_access.sv */
// program_memory_self_access: apb register file and sequencer for self-reprogramming of flash
`timescale 1ns/1ps
// Function
// - config select redirects accesses to config region
// - unsupported config read clears both data bytes
// - user ids, device id, config words readable
// - only user id words are writable
// - low data byte eight bits, kept over reset
// - high data six bits, top two read zero
// - low address byte, cleared on reset
// - high address seven bits, bit seven reads one
// - write starts only after 55h then AAh
// - processor halted until program operation completes
module program_memory_self_access #(
    parameter logic [13:0] DEVICE_ID_WORD = 14'h1234, // arbitrary value
    parameter logic [13:0] CONFIG_WORD_1 = 14'h3FFF,
    parameter logic [13:0] CONFIG_WORD_2 = 14'h3FFF
) (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output nvm_self_access_pkg::mem_req_type MEM_REQ,
    input wire nvm_self_access_pkg::mem_rsp_type MEM_RSP,
    output logic CPU_HALT
);

    // --------
    // state
    // --------
    typedef enum logic [1:0] {UL_NONE, UL_FIRST, UL_ARMED} unlock_type;
    typedef enum logic {SEQ_IDLE, SEQ_BUSY} seq_type;

    logic [7:0] data_low_ff, nxt_data_low;
    logic [5:0] data_high_ff, nxt_data_high;
    logic [7:0] addr_low_ff, nxt_addr_low;
    logic [6:0] addr_high_ff, nxt_addr_high;
    logic program_space_ff, nxt_program_space;
    logic config_space_ff, nxt_config_space;
    logic latch_only_ff, nxt_latch_only;
    logic erase_ff, nxt_erase;
    logic write_enable_ff, nxt_write_enable;
    logic write_start_ff, nxt_write_start;
    logic read_start_ff, nxt_read_start;
    logic [13:0] user_id_ff [4];
    logic [13:0] nxt_user_id [4];
    unlock_type unlock_ff, nxt_unlock;
    seq_type seq_ff, nxt_seq;
    nvm_self_access_pkg::mem_req_type req_ff, nxt_req;
    logic halt_ff, nxt_halt;
    logic [31:0] rdata_ff, nxt_rdata;

    logic apb_wr;
    logic mapped;
    logic [14:0] full_addr;
    logic [13:0] cfg_word;
    logic cfg_hit;
    logic start_write;
    logic start_read;

    // --------
    // decode
    // --------
    assign apb_wr = PSEL && PENABLE && PWRITE;
    assign full_addr = {addr_high_ff, addr_low_ff};
    assign mapped = (PADDR == nvm_self_access_pkg::OFS_DATA_LOW)
        || (PADDR == nvm_self_access_pkg::OFS_DATA_HIGH)
        || (PADDR == nvm_self_access_pkg::OFS_ADDR_LOW)
        || (PADDR == nvm_self_access_pkg::OFS_ADDR_HIGH)
        || (PADDR == nvm_self_access_pkg::OFS_CONTROL)
        || (PADDR == nvm_self_access_pkg::OFS_UNLOCK);
    // zero wait states; unmapped offsets answer with an error
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !mapped;
    assign PRDATA = rdata_ff;
    assign MEM_REQ = req_ff;
    assign CPU_HALT = halt_ff;

    // config region lookup; anything unlisted reads as zero
    always_comb begin
        cfg_word = 14'h0000;
        cfg_hit = 1'b1;
        if (full_addr <= nvm_self_access_pkg::CFG_USER_ID_LAST) begin
            cfg_word = user_id_ff[full_addr[1:0]];
        end else if (full_addr == nvm_self_access_pkg::CFG_DEVICE_ID) begin
            cfg_word = DEVICE_ID_WORD;
        end else if (full_addr == nvm_self_access_pkg::CFG_WORD_1) begin
            cfg_word = CONFIG_WORD_1;
        end else if (full_addr == nvm_self_access_pkg::CFG_WORD_2) begin
            cfg_word = CONFIG_WORD_2;
        end else begin
            cfg_hit = 1'b0;
        end
    end

    // --------
    // register file and sequencer next state
    // --------
    always_comb begin
        nxt_data_low = data_low_ff;
        nxt_data_high = data_high_ff;
        nxt_addr_low = addr_low_ff;
        nxt_addr_high = addr_high_ff;
        nxt_program_space = program_space_ff;
        nxt_config_space = config_space_ff;
        nxt_latch_only = latch_only_ff;
        nxt_erase = erase_ff;
        nxt_write_enable = write_enable_ff;
        nxt_write_start = write_start_ff;
        nxt_read_start = read_start_ff;
        nxt_user_id = user_id_ff;
        nxt_unlock = unlock_ff;
        nxt_seq = seq_ff;
        nxt_req = req_ff;
        nxt_halt = halt_ff;
        nxt_rdata = rdata_ff;
        start_write = 1'b0;
        start_read = 1'b0;

        // setup phase loads read data so it is stable in the access phase
        if (PSEL && !PENABLE && !PWRITE) begin
            unique case (PADDR)
                nvm_self_access_pkg::OFS_DATA_LOW: nxt_rdata = {24'h00_0000, data_low_ff};
                nvm_self_access_pkg::OFS_DATA_HIGH: nxt_rdata = {26'h000_0000, data_high_ff};
                nvm_self_access_pkg::OFS_ADDR_LOW: nxt_rdata = {24'h00_0000, addr_low_ff};
                nvm_self_access_pkg::OFS_ADDR_HIGH:
                    nxt_rdata = {24'h00_0000, 1'b1, addr_high_ff};
                nvm_self_access_pkg::OFS_CONTROL: nxt_rdata = {24'h00_0000, program_space_ff,
                    config_space_ff, latch_only_ff, erase_ff, 1'b0, write_enable_ff,
                    write_start_ff, read_start_ff};
                default: nxt_rdata = 32'h0000_0000;
            endcase
        end

        if (apb_wr) begin
            // any write breaks the key sequence unless it continues it
            nxt_unlock = UL_NONE;
            unique case (PADDR)
                nvm_self_access_pkg::OFS_DATA_LOW: nxt_data_low = PWDATA[7:0];
                nvm_self_access_pkg::OFS_DATA_HIGH: nxt_data_high = PWDATA[5:0];
                nvm_self_access_pkg::OFS_ADDR_LOW: nxt_addr_low = PWDATA[7:0];
                nvm_self_access_pkg::OFS_ADDR_HIGH: nxt_addr_high = PWDATA[6:0];
                nvm_self_access_pkg::OFS_UNLOCK: begin
                    if (PWDATA[7:0] == nvm_self_access_pkg::UNLOCK_KEY_FIRST) begin
                        nxt_unlock = UL_FIRST;
                    end else if (PWDATA[7:0] == nvm_self_access_pkg::UNLOCK_KEY_SECOND
                                 && unlock_ff == UL_FIRST) begin
                        nxt_unlock = UL_ARMED;
                    end
                end
                nvm_self_access_pkg::OFS_CONTROL: begin
                    // mode bits frozen while an operation runs
                    if (seq_ff == SEQ_IDLE) begin
                        nxt_program_space = PWDATA[nvm_self_access_pkg::BIT_PROGRAM_SPACE];
                        nxt_config_space = PWDATA[nvm_self_access_pkg::BIT_CONFIG_SPACE];
                        nxt_latch_only = PWDATA[nvm_self_access_pkg::BIT_LATCH_ONLY];
                        nxt_erase = PWDATA[nvm_self_access_pkg::BIT_ERASE];
                        start_write = PWDATA[nvm_self_access_pkg::BIT_WRITE_START]
                            && PWDATA[nvm_self_access_pkg::BIT_WRITE_ENABLE]
                            && unlock_ff == UL_ARMED;
                        start_read = PWDATA[nvm_self_access_pkg::BIT_READ_START]
                            && !start_write;
                    end
                    nxt_write_enable = PWDATA[nvm_self_access_pkg::BIT_WRITE_ENABLE];
                end
                default: begin
                end
            endcase
        end

        unique case (seq_ff)
            SEQ_IDLE: begin
                if (start_read && nxt_config_space) begin
                    // config reads resolve locally, ready next cycle
                    nxt_data_low = cfg_hit ? cfg_word[7:0] : 8'h00;
                    nxt_data_high = cfg_hit ? cfg_word[13:8] : 6'h00;
                end else if (start_read) begin
                    nxt_req.valid = 1'b1;
                    nxt_req.op = nxt_program_space ? nvm_self_access_pkg::OP_READ_PROGRAM
                        : nvm_self_access_pkg::OP_READ_EEPROM;
                    nxt_req.addr = full_addr;
                    nxt_req.wdata = 14'h0000;
                    nxt_read_start = 1'b1;
                    nxt_halt = 1'b1;
                    nxt_seq = SEQ_BUSY;
                end else if (start_write && nxt_config_space) begin
                    // only user id words accept writes; others untouched
                    if (full_addr <= nvm_self_access_pkg::CFG_USER_ID_LAST
                        && !nxt_latch_only) begin
                        nxt_user_id[full_addr[1:0]] = nxt_erase
                            ? nvm_self_access_pkg::ERASED_WORD
                            : {data_high_ff, data_low_ff};
                    end
                    nxt_erase = 1'b0;
                end else if (start_write) begin
                    nxt_req.valid = 1'b1;
                    nxt_req.addr = full_addr;
                    nxt_req.wdata = {data_high_ff, data_low_ff};
                    if (!nxt_program_space) begin
                        nxt_req.op = nvm_self_access_pkg::OP_WRITE_EEPROM;
                    end else if (nxt_erase) begin
                        nxt_req.op = nvm_self_access_pkg::OP_ERASE_ROW;
                    end else if (nxt_latch_only) begin
                        nxt_req.op = nvm_self_access_pkg::OP_LOAD_LATCH;
                    end else begin
                        nxt_req.op = nvm_self_access_pkg::OP_PROGRAM_ROW;
                    end
                    // eeprom writes run in the background; flash halts the core
                    nxt_halt = nxt_program_space;
                    nxt_write_start = 1'b1;
                    nxt_seq = SEQ_BUSY;
                end
            end
            SEQ_BUSY: begin
                if (MEM_RSP.done) begin
                    if (req_ff.op == nvm_self_access_pkg::OP_READ_PROGRAM
                        || req_ff.op == nvm_self_access_pkg::OP_READ_EEPROM) begin
                        // array data beats a simultaneous software write
                        nxt_data_low = MEM_RSP.rdata[7:0];
                        nxt_data_high = req_ff.op == nvm_self_access_pkg::OP_READ_PROGRAM
                            ? MEM_RSP.rdata[13:8] : 6'h00;
                    end
                    if (req_ff.op == nvm_self_access_pkg::OP_ERASE_ROW) begin
                        nxt_erase = 1'b0;
                    end
                    nxt_req.valid = 1'b0;
                    nxt_write_start = 1'b0;
                    nxt_read_start = 1'b0;
                    nxt_halt = 1'b0;
                    nxt_seq = SEQ_IDLE;
                end
            end
        endcase
    end

    // --------
    // registers
    // --------
    // data bytes keep their value across reset
    always_ff @(posedge CLOCK) begin
        data_low_ff <= nxt_data_low;
        data_high_ff <= nxt_data_high;
    end

    always_ff @(posedge CLOCK) begin
        if (!RSTN) begin
            addr_low_ff <= nvm_self_access_pkg::RST_ADDR_LOW;
            addr_high_ff <= nvm_self_access_pkg::RST_ADDR_HIGH;
            program_space_ff <= 1'b0;
            config_space_ff <= 1'b0;
            latch_only_ff <= 1'b0;
            erase_ff <= 1'b0;
            write_enable_ff <= 1'b0;
            write_start_ff <= 1'b0;
            read_start_ff <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                user_id_ff[i] <= nvm_self_access_pkg::RST_USER_ID;
            end
            unlock_ff <= UL_NONE;
            seq_ff <= SEQ_IDLE;
            req_ff <= '0;
            halt_ff <= 1'b0;
            rdata_ff <= 32'h0000_0000;
        end else begin
            addr_low_ff <= nxt_addr_low;
            addr_high_ff <= nxt_addr_high;
            program_space_ff <= nxt_program_space;
            config_space_ff <= nxt_config_space;
            latch_only_ff <= nxt_latch_only;
            erase_ff <= nxt_erase;
            write_enable_ff <= nxt_write_enable;
            write_start_ff <= nxt_write_start;
            read_start_ff <= nxt_read_start;
            user_id_ff <= nxt_user_id;
            unlock_ff <= nxt_unlock;
            seq_ff <= nxt_seq;
            req_ff <= nxt_req;
            halt_ff <= nxt_halt;
            rdata_ff <= nxt_rdata;
        end
    end

endmodule : program_memory_self_access

/* test/nvm_self_access_chk.sv */
// checker: port-level assertions for the nvm self-access block
`timescale 1ns/1ps
module nvm_self_access_chk (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire nvm_self_access_pkg::mem_req_type MEM_REQ,
    input wire nvm_self_access_pkg::mem_rsp_type MEM_RSP,
    input wire logic CPU_HALT
);
    // --------
    // shadow of unlock state and address pair
    // --------
    logic wr_now;
    logic rd_now;
    logic [1:0] key_ff, nxt_key;
    logic [14:0] adr_ff, nxt_adr;
    assign wr_now = PSEL && PENABLE && PWRITE;
    assign rd_now = PSEL && PENABLE && !PWRITE;
    always_comb begin
        nxt_key = key_ff;
        nxt_adr = adr_ff;
        if (wr_now) begin
            // any write breaks the key chain
            nxt_key = 2'h0;
            if (PADDR == nvm_self_access_pkg::OFS_UNLOCK) begin
                nxt_key = PWDATA[7:0] == 8'h55 ? 2'h1
                    : (PWDATA[7:0] == 8'hAA && key_ff == 2'h1) ? 2'h2 : 2'h0;
            end
            if (PADDR == nvm_self_access_pkg::OFS_ADDR_LOW) nxt_adr[7:0] = PWDATA[7:0];
            if (PADDR == nvm_self_access_pkg::OFS_ADDR_HIGH) nxt_adr[14:8] = PWDATA[6:0];
        end
    end
    always_ff @(posedge CLOCK) begin
        key_ff <= RSTN ? nxt_key : 2'h0;
        adr_ff <= RSTN ? nxt_adr : 15'h0000;
    end
    // --------
    // assertions
    // --------
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    sequence req_open; MEM_REQ.valid && !MEM_RSP.done; endsequence
    sequence req_close; MEM_REQ.valid && MEM_RSP.done; endsequence
    sequence req_start; $rose(MEM_REQ.valid); endsequence
    sequence wr_start;
        req_start ##0 !(MEM_REQ.op inside {nvm_self_access_pkg::OP_READ_PROGRAM,
            nvm_self_access_pkg::OP_READ_EEPROM});
    endsequence
    AST_HOLD: assert property (req_open |=> MEM_REQ.valid && $stable(MEM_REQ.op)
        && $stable(MEM_REQ.addr)) else $error("request changed before done");
    AST_CLOSE: assert property (req_close |=> !MEM_REQ.valid && !CPU_HALT)
        else $error("request or halt not released after done");
    AST_HALT: assert property (MEM_REQ.valid |->
        CPU_HALT == (MEM_REQ.op != nvm_self_access_pkg::OP_WRITE_EEPROM))
        else $error("halt level wrong for pending operation");
    AST_UNLOCK: assert property (wr_start |->
        $past(wr_now && PADDR == nvm_self_access_pkg::OFS_CONTROL && key_ff == 2'h2))
        else $error("write started without key sequence");
    AST_ADDR: assert property (req_start |-> MEM_REQ.addr == adr_ff)
        else $error("request address differs from address pair");
    AST_SPACE: assert property (req_start |-> $past(PWDATA[7]) ==
        !(MEM_REQ.op inside {nvm_self_access_pkg::OP_READ_EEPROM,
        nvm_self_access_pkg::OP_WRITE_EEPROM})) else $error("wrong memory space");
    AST_CFG: assert property (wr_now && PADDR == nvm_self_access_pkg::OFS_CONTROL
        && PWDATA[6] && !MEM_REQ.valid |=> !MEM_REQ.valid) else $error("config hit array");
    AST_DHI: assert property (rd_now && PADDR == nvm_self_access_pkg::OFS_DATA_HIGH
        |-> PRDATA[31:6] == 26'h000_0000) else $error("data high upper bits set");
    AST_AHI: assert property (rd_now && PADDR == nvm_self_access_pkg::OFS_ADDR_HIGH
        |-> PRDATA == {24'h00_0000, 1'b1, adr_ff[14:8]}) else $error("address high wrong");
    AST_ALO: assert property (rd_now && PADDR == nvm_self_access_pkg::OFS_ADDR_LOW
        |-> PRDATA == {24'h00_0000, adr_ff[7:0]}) else $error("address low wrong");
endmodule : nvm_self_access_chk
bind program_memory_self_access nvm_self_access_chk chk (.CLOCK(CLOCK), .RSTN(RSTN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ),
    .MEM_RSP(MEM_RSP), .CPU_HALT(CPU_HALT));

/* test/nvm_array_model.sv */
// far-side model: flash and data eeprom arrays answering memory requests
`timescale 1ns/1ps
module nvm_array_model (
    input wire logic CLOCK,
    input wire logic RSTN,
    input wire logic SLOW,
    input wire nvm_self_access_pkg::mem_req_type MEM_REQ,
    output nvm_self_access_pkg::mem_rsp_type MEM_RSP
);
    logic [13:0] flash [0:255];
    logic [13:0] ee [0:255];
    logic [13:0] lat [0:31];
    logic [13:0] junk = 14'h0A5C;
    logic [7:0] a;
    int cnt = 0;
    initial begin
        for (int i = 0; i < 256; i++) begin
            flash[i] = 14'(i * 3 + 1);
            ee[i] = 14'(i ^ 8'h5A);
        end
        for (int i = 0; i < 32; i++) lat[i] = 14'h3FFF;
    end
    assign a = MEM_REQ.addr[7:0];
    always @(posedge CLOCK) begin
        // read data outside done keeps moving, never a stale word
        junk <= junk + 14'h1357;
        MEM_RSP.done <= 1'b0;
        MEM_RSP.rdata <= junk;
        if (!RSTN) cnt <= 0;
        else if (MEM_REQ.valid && !MEM_RSP.done) begin
            cnt <= cnt + 1;
            if (cnt >= (SLOW ? 4 : 0)) begin
                cnt <= 0;
                MEM_RSP.done <= 1'b1;
                case (MEM_REQ.op)
                    nvm_self_access_pkg::OP_READ_PROGRAM: MEM_RSP.rdata <= flash[a];
                    nvm_self_access_pkg::OP_READ_EEPROM: MEM_RSP.rdata <= ee[a];
                    nvm_self_access_pkg::OP_ERASE_ROW: for (int j = 0; j < 32; j++)
                        flash[{a[7:5], 5'(j)}] = 14'h3FFF;
                    nvm_self_access_pkg::OP_LOAD_LATCH: lat[a[4:0]] = MEM_REQ.wdata;
                    nvm_self_access_pkg::OP_PROGRAM_ROW: begin
                        lat[a[4:0]] = MEM_REQ.wdata;
                        for (int j = 0; j < 32; j++) begin
                            flash[{a[7:5], 5'(j)}] = lat[j];
                            lat[j] = 14'h3FFF;
                        end
                    end
                    default: ee[a] = {6'h00, MEM_REQ.wdata[7:0]};
                endcase
            end
        end
    end
endmodule : nvm_array_model

/* test/program_memory_self_access_tb_top.sv */
// testbench: apb-driven scenarios for the nvm self-access block
`timescale 1ns/1ps
module program_memory_self_access_tb_top;
    localparam logic [7:0] dl = nvm_self_access_pkg::OFS_DATA_LOW;
    localparam logic [7:0] dh = nvm_self_access_pkg::OFS_DATA_HIGH;
    localparam logic [7:0] al = nvm_self_access_pkg::OFS_ADDR_LOW;
    localparam logic [7:0] ah = nvm_self_access_pkg::OFS_ADDR_HIGH;
    localparam logic [7:0] ct = nvm_self_access_pkg::OFS_CONTROL;
    localparam logic [7:0] ul = nvm_self_access_pkg::OFS_UNLOCK;
    localparam logic [13:0] dev_id = 14'h2BCD; // arbitrary value
    logic CLOCK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, SLOW = 0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0000_0000;
    logic [31:0] PRDATA, q, pair, d;
    logic PREADY, PSLVERR, CPU_HALT, e;
    nvm_self_access_pkg::mem_req_type MEM_REQ;
    nvm_self_access_pkg::mem_rsp_type MEM_RSP;
    int err_count = 0, compares = 0, seed = 32'h0000_78ec, k;
    logic [7:0] ofs [0:3] = '{dl, dh, al, ah};
    logic [31:0] msk [0:3] = '{32'hFF, 32'h3F, 32'hFF, 32'h7F};
    int cfg_adr [0:10] = '{0, 1, 2, 3, 6, 7, 8, 4, 5, 9, 127};
    logic [13:0] uid [0:3] = '{4{14'h3FFF}};
    logic [13:0] ram [0:31];
    logic [13:0] w;
    always #10 CLOCK = ~CLOCK;
    program_memory_self_access #(.DEVICE_ID_WORD(dev_id), .CONFIG_WORD_1(14'h1A2B),
        .CONFIG_WORD_2(14'h0C3D)) uut (.CLOCK(CLOCK), .RSTN(RSTN), .PSEL(PSEL),
        .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
        .PREADY(PREADY), .PSLVERR(PSLVERR), .MEM_REQ(MEM_REQ), .MEM_RSP(MEM_RSP),
        .CPU_HALT(CPU_HALT));
    nvm_array_model far (.CLOCK(CLOCK), .RSTN(RSTN), .SLOW(SLOW), .MEM_REQ(MEM_REQ),
        .MEM_RSP(MEM_RSP));
    // --------
    // expectations, checks and bus tasks
    // --------
    function automatic logic [13:0] f_cfg(input int a);
        if (a < 4) return uid[a];
        if (a == 6) return dev_id;
        if (a == 7) return 14'h1A2B;
        return (a == 8) ? 14'h0C3D : 14'h0000;
    endfunction : f_cfg
    task close_out();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic chk_word(input string n, input logic [31:0] x, input logic [31:0] g);
        compares++;
        if (g !== x) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", n, x, g);
        end
    endtask : chk_word
    task automatic chk_flag(input string n, input logic x, input logic g);
        chk_word(n, {31'h0, x}, {31'h0, g});
    endtask : chk_flag
    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic apb(input logic wr_i, input logic [7:0] a_i, input logic [31:0] d_i);
        int n = 0;
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr_i;
        PADDR <= a_i;
        PWDATA <= d_i;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
            n++;
        end while (PREADY !== 1'b1 && n < 20);
        q = PRDATA;
        e = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        if (PREADY !== 1'b1) begin
            err_count++;
            close_out();
        end
        @(posedge CLOCK);
    endtask : apb
    task automatic wr(input logic [7:0] a_i, input logic [31:0] d_i);
        apb(1'b1, a_i, d_i);
    endtask : wr
    task automatic rd_pair();
        apb(1'b0, dl, 32'h0);
        pair = q;
        apb(1'b0, dh, 32'h0);
        pair = {q[23:0], pair[7:0]};
    endtask : rd_pair
    task automatic op(input logic [31:0] c, input logic key);
        int n = 0;
        SLOW <= 1'($random(seed));
        if (key) begin
            wr(ul, 32'h55);
            wr(ul, 32'hAA);
        end
        wr(ct, c);
        chk_flag("halt", !c[6] && (c[0] || c[7]), CPU_HALT);
        do begin
            apb(1'b0, ct, 32'h0);
            n++;
        end while (q[1:0] !== 2'b00 && n < 40);
        if (q[1:0] !== 2'b00) begin
            err_count++;
            close_out();
        end
    endtask : op
    task automatic cfg_check();
        for (int i = 0; i < 11; i++) begin
            wr(dl, 32'hA5);
            wr(dh, 32'h15);
            wr(al, 32'(cfg_adr[i]));
            op(32'h41, 1'b0);
            rd_pair();
            chk_word("config word", 32'(f_cfg(cfg_adr[i])), pair);
        end
    endtask : cfg_check
    // --------
    // main sequence
    // --------
    initial begin
        repeat (20) @(posedge CLOCK);
        RSTN <= 1'b1;
        @(posedge CLOCK);
        wr(dl, 32'h3C);
        apb(1'b0, al, 32'h0);
        chk_word("addr low reset", 32'h00, q);
        apb(1'b0, ah, 32'h0);
        chk_word("addr high reset", 32'h80, q);
        apb(1'b0, 8'h18, 32'h0);
        chk_flag("unmapped error", 1'b1, e);
        RSTN <= 1'b0;
        @(posedge CLOCK);
        RSTN <= 1'b1;
        @(posedge CLOCK);
        apb(1'b0, dl, 32'h0);
        chk_word("data low over reset", 32'h3C, q);
        $display("test reset done");
        for (int i = 0; i < 16; i++) begin
            k = i % 4;
            d = $random(seed);
            wr(ofs[k], d);
            apb(1'b0, ofs[k], 32'h0);
            chk_word("register", (d & msk[k]) | (k == 3 ? 32'h80 : 32'h0), q);
        end
        $display("test registers done");
        wr(ah, 32'h0);
        for (int i = 0; i < 6; i++) begin
            d = $random(seed);
            wr(al, d);
            op(32'h81, 1'b0);
            rd_pair();
            chk_word("flash word", 32'(14'(d[7:0] * 3 + 1)), pair);
            op(32'h01, 1'b0);
            rd_pair();
            chk_word("eeprom byte", {24'h0, d[7:0] ^ 8'h5A}, pair);
        end
        $display("test reads done");
        cfg_check();
        w = 14'($random(seed));
        uid[2] = w;
        for (int i = 0; i < 3; i++) begin
            wr(al, 32'(cfg_adr[2 * i + 2]));
            wr(dl, {24'h0, w[7:0]});
            wr(dh, {26'h0, w[13:8]});
            op(32'h46, 1'b1);
        end
        cfg_check();
        $display("test config done");
        wr(al, 32'h21);
        wr(dl, 32'h9E);
        wr(ul, 32'h55);
        wr(dl, 32'h9E);
        wr(ul, 32'hAA);
        wr(ct, 32'h06);
        apb(1'b0, ct, 32'h0);
        chk_flag("broken key start", 1'b0, q[1]);
        wr(ul, 32'hAA);
        wr(ul, 32'h55);
        wr(ct, 32'h06);
        apb(1'b0, ct, 32'h0);
        chk_flag("reversed key start", 1'b0, q[1]);
        op(32'h06, 1'b1);
        op(32'h01, 1'b0);
        rd_pair();
        chk_word("eeprom verify", 32'h9E, pair);
        $display("test eeprom write done");
        for (int i = 0; i < 32; i++) begin
            wr(al, 32'h40 + i);
            op(32'h81, 1'b0);
            rd_pair();
            ram[i] = pair[13:0];
        end
        w = 14'($random(seed));
        ram[5] = w;
        wr(al, 32'h40);
        op(32'h96, 1'b1);
        for (int i = 0; i < 32; i++) begin
            wr(al, 32'h40 + i);
            wr(dl, {24'h0, ram[i][7:0]});
            wr(dh, {26'h0, ram[i][13:8]});
            op(i == 31 ? 32'h86 : 32'hA6, 1'b1);
        end
        for (int i = 0; i < 32; i++) begin
            wr(al, 32'h40 + i);
            op(32'h81, 1'b0);
            rd_pair();
            chk_word("row word", 32'(i == 5 ? w : 14'((64 + i) * 3 + 1)), pair);
        end
        $display("test row rewrite done");
        close_out();
    end
endmodule : program_memory_self_access_tb_top
